// ---- verilog/cicd_chain.sv ----
/*
 * Receive front: tuning-word register with oscillator phase and sync
 * handling, a second-order decimator on parallel I/Q, a time-multiplexed
 * hand-over and a fifth-order decimator on the shared I/Q stream.
 * Assumes mixer samples on clk, an async sync pin, and a plain register port.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Master mode: tuning-word access forces oscillator phase sync
// - Slave mode: tuning write makes no sync
// - Back to master after a slave tuning write: sync at next wrap
// - Second stage takes every input sample
// - Second ratio 1..16, one out per ratio
// - I/Q parallel, then one shared path
// - Two integrators, two combs, gain over 2^(s+2)
// - Second scale 0..6, one-bit shift each
// - Second scale applies even at ratio 1
// - Fifth ratio 1..32, one out per ratio
// - Fifth ratio 1 bypasses, scale ignored
// - Five integrators, five combs, gain over 2^(s+5)
// - Fifth scale 0..20, 6 dB steps
// - Control bit picks sync master or slave
// - Tuning word is 32-bit unsigned
module cicd_chain
    import cicd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [CICD_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Mixer samples in
    input wire logic in_valid,
    input wire cicd_iq_s in_iq,
    // Decimated stream out
    output logic out_valid,
    output cicd_word_s out_word,
    // Oscillator phase to the mixer
    output logic [31:0] osc_phase,
    // Sync pin, split
    input wire logic osc_sync_pin_in,
    output logic osc_sync_pin_out,
    output logic osc_sync_pin_oe_n
);

    localparam int W2 = CICD_IW + CICD_G2;  // Second-stage accumulator width
    localparam int W5 = CICD_IW + CICD_G5;  // Fifth-stage accumulator width

    // Configuration registers
    logic ms_r;                  // 1 = sync master
    logic [31:0] tune_r;         // Tuning word
    logic [4:0] r2_r;            // Second ratio
    logic [2:0] s2_r;            // Second scale
    logic [5:0] r5_r;            // Fifth ratio
    logic [4:0] s5_r;            // Fifth scale

    // Sync and phase state
    logic sy1_r, sy2_r;          // Pin synchroniser
    logic pend_r;                // Wrap sync owed after slave write
    logic [31:0] phase_r;
    logic sync_out_r, oe_n_r;
    logic [31:0] rdata_r;

    // Address hits
    wire hit_ctrl = (reg_addr == CICD_OFS_CTRL);
    wire hit_tune = (reg_addr == CICD_OFS_TUNE);
    wire hit_r2 = (reg_addr == CICD_OFS_R2);
    wire hit_s2 = (reg_addr == CICD_OFS_S2);
    wire hit_r5 = (reg_addr == CICD_OFS_R5);
    wire hit_s5 = (reg_addr == CICD_OFS_S5);
    wire tune_acc = hit_tune && (reg_wr || reg_rd);

    // Clamped write values
    wire [4:0] r2_nxt = (reg_wdata[4:0] == 5'h00) ? 5'h01 :
                        (reg_wdata[4:0] > CICD_R2_MAX) ? CICD_R2_MAX : reg_wdata[4:0];
    wire [2:0] s2_nxt = (reg_wdata[2:0] > CICD_S2_MAX) ? CICD_S2_MAX : reg_wdata[2:0];
    wire [5:0] r5_nxt = (reg_wdata[5:0] == 6'h00) ? 6'h01 :
                        (reg_wdata[5:0] > CICD_R5_MAX) ? CICD_R5_MAX : reg_wdata[5:0];
    wire [4:0] s5_nxt = (reg_wdata[4:0] > CICD_S5_MAX) ? CICD_S5_MAX : reg_wdata[4:0];

    // Phase advance and wrap through zero
    wire [32:0] phase_sum = {1'b0, phase_r} + {1'b0, tune_r};
    wire wrap = in_valid && phase_sum[32];

    // Sync events by role
    wire mst_evt = ms_r && (tune_acc || (pend_r && wrap));
    wire slv_evt = !ms_r && sy2_r;
    wire sync_evt = mst_evt || slv_evt;
    wire pend_set = !ms_r && reg_wr && hit_tune;

    // Configuration writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_r <= CICD_MS_RST;
            tune_r <= CICD_TUNE_RST;
            r2_r <= CICD_R2_RST;
            s2_r <= CICD_S2_RST;
            r5_r <= CICD_R5_RST;
            s5_r <= CICD_S5_RST;
        end else if (reg_wr) begin
            if (hit_ctrl) ms_r <= reg_wdata[CICD_CTRL_MS_BIT];
            if (hit_tune) tune_r <= reg_wdata;
            if (hit_r2) r2_r <= r2_nxt;
            if (hit_s2) s2_r <= s2_nxt;
            if (hit_r5) r5_r <= r5_nxt;
            if (hit_s5) s5_r <= s5_nxt;
        end
    end

    // Read mux
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_val[CICD_CTRL_MS_BIT] = ms_r;
        end else if (hit_tune) begin
            rd_val = tune_r;
        end else if (hit_r2) begin
            rd_val[4:0] = r2_r;
        end else if (hit_s2) begin
            rd_val[2:0] = s2_r;
        end else if (hit_r5) begin
            rd_val[5:0] = r5_r;
        end else if (hit_s5) begin
            rd_val[4:0] = s5_r;
        end else if (reg_addr == CICD_OFS_STAT) begin
            rd_val[CICD_CTRL_MS_BIT] = ms_r;
            rd_val[CICD_STAT_PEND_BIT] = pend_r;
        end else if (reg_addr == CICD_OFS_PHASE) begin
            rd_val = phase_r;
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) rdata_r <= 32'h0000_0000;
        else rdata_r <= reg_rd ? rd_val : 32'h0000_0000;
    end

    // Pin synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sy1_r <= 1'b0;
            sy2_r <= 1'b0;
        end else begin
            sy1_r <= osc_sync_pin_in;
            sy2_r <= sy1_r;
        end
    end

    // Phase accumulator; a held slave pulse holds it at zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) phase_r <= 32'h0000_0000;
        else if (sync_evt) phase_r <= 32'h0000_0000;
        else if (in_valid) phase_r <= phase_sum[31:0];
    end

    // Owed wrap sync; a new slave write wins over the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) pend_r <= 1'b0;
        else if (pend_set) pend_r <= 1'b1;
        else if (ms_r && (tune_acc || wrap)) pend_r <= 1'b0;
    end

    // Pin drive: pulse as master, released as slave
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_out_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else begin
            sync_out_r <= mst_evt;
            oe_n_r <= !ms_r;
        end
    end

    // Second-order decimation count, every input sample
    logic [4:0] cnt2_r;
    // At or past the end, so a lowered ratio never lets the count run on
    wire dec2 = in_valid && (cnt2_r >= r2_r - 5'h01);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cnt2_r <= 5'h00;
        else if (in_valid) cnt2_r <= dec2 ? 5'h00 : cnt2_r + 5'h01;
    end

    // Second-order stage, I and Q in parallel
    wire [5:0] sh2 = {3'b000, s2_r} + CICD_S2_BIAS;
    logic signed [CICD_IW-1:0] y2 [2];
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_c2
            logic signed [W2-1:0] ia_r, ib_r, ca_r, cb_r;
            wire signed [CICD_IW-1:0] xin = (c == 0) ? in_iq.i : in_iq.q;
            wire signed [W2-1:0] x = {{CICD_G2{xin[CICD_IW-1]}}, xin};
            wire signed [W2-1:0] a0 = ia_r + x;
            wire signed [W2-1:0] a1 = ib_r + a0;
            wire signed [W2-1:0] d0 = a1 - ca_r;
            wire signed [W2-1:0] d1 = d0 - cb_r;
            wire signed [W2-1:0] sh = d1 >>> sh2;
            assign y2[c] = sh[CICD_IW-1:0];
            // Integrators each sample, combs once per ratio
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ia_r <= '0;
                    ib_r <= '0;
                    ca_r <= '0;
                    cb_r <= '0;
                end else if (in_valid) begin
                    ia_r <= a0;
                    ib_r <= a1;
                    if (dec2) begin
                        ca_r <= a1;
                        cb_r <= d0;
                    end
                end
            end
        end
    endgenerate

    // Second-stage output pair
    cicd_iq_s c2y_r;
    logic c2v_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            c2y_r <= '0;
            c2v_r <= 1'b0;
        end else begin
            c2v_r <= dec2;
            if (dec2) c2y_r <= {y2[0], y2[1]};
        end
    end

    // Interleave I then Q onto one shared path
    cicd_word_s mx_r;
    logic mxv_r, qpend_r;
    logic signed [CICD_IW-1:0] qhold_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mx_r <= '0;
            mxv_r <= 1'b0;
            qpend_r <= 1'b0;
            qhold_r <= '0;
        end else if (c2v_r) begin
            mx_r <= {1'b0, c2y_r.i};
            mxv_r <= 1'b1;
            qhold_r <= c2y_r.q;
            qpend_r <= 1'b1;
        end else if (qpend_r) begin
            mx_r <= {1'b1, qhold_r};
            mxv_r <= 1'b1;
            qpend_r <= 1'b0;
        end else begin
            mxv_r <= 1'b0;
        end
    end

    // Fifth-order count on I words; Q reuses the I decision
    logic [5:0] cnt5_r;
    logic take_q_r;
    wire dec5_i = (cnt5_r >= r5_r - 6'h01);  // Lowered ratio acts at once
    wire take = mxv_r && (mx_r.is_q ? take_q_r : dec5_i);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt5_r <= 6'h00;
            take_q_r <= 1'b0;
        end else if (mxv_r && !mx_r.is_q) begin
            cnt5_r <= dec5_i ? 6'h00 : cnt5_r + 6'h01;
            take_q_r <= dec5_i;
        end
    end

    // Fifth-order stage, state per channel on the shared path
    wire [5:0] sh5 = {1'b0, s5_r} + CICD_S5_BIAS;
    wire signed [W5-1:0] x5 = {{CICD_G5{mx_r.data[CICD_IW-1]}}, mx_r.data};
    logic signed [CICD_IW-1:0] y5 [2];
    generate
        for (c = 0; c < 2; c++) begin : g_c5
            logic signed [W5-1:0] it_r [5];
            logic signed [W5-1:0] cm_r [5];
            wire signed [W5-1:0] a [5];
            wire signed [W5-1:0] d [5];
            wire signed [W5-1:0] sh = d[4] >>> sh5;
            wire mine = mxv_r && (mx_r.is_q == (c != 0));
            genvar k;
            assign a[0] = it_r[0] + x5;
            assign d[0] = a[4] - cm_r[0];
            for (k = 1; k < 5; k++) begin : g_k
                assign a[k] = it_r[k] + a[k-1];
                assign d[k] = d[k-1] - cm_r[k];
            end
            assign y5[c] = sh[CICD_IW-1:0];
            // Integrators per word, combs once per ratio
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    for (int j = 0; j < 5; j++) begin
                        it_r[j] <= '0;
                        cm_r[j] <= '0;
                    end
                end else if (mine) begin
                    for (int j = 0; j < 5; j++) begin
                        it_r[j] <= a[j];
                    end
                    if (take) begin
                        cm_r[0] <= a[4];
                        for (int j = 1; j < 5; j++) begin
                            cm_r[j] <= d[j-1];
                        end
                    end
                end
            end
        end
    endgenerate

    // Output word; ratio 1 passes data unscaled
    wire bypass5 = (r5_r == 6'h01);
    wire signed [CICD_IW-1:0] y_sel = bypass5 ? mx_r.data : y5[mx_r.is_q];
    cicd_word_s out_r;
    logic outv_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= '0;
            outv_r <= 1'b0;
        end else begin
            outv_r <= take;
            if (take) out_r <= {mx_r.is_q, y_sel};
        end
    end

    // Outputs
    assign reg_rdata = rdata_r;
    assign out_valid = outv_r;
    assign out_word = out_r;
    assign osc_phase = phase_r;
    assign osc_sync_pin_out = sync_out_r;
    assign osc_sync_pin_oe_n = oe_n_r;

endmodule // cicd_chain

`default_nettype wire

// ---- verilog/cicd_pkg.sv ----
/*
 * Shared constants and carriers for the two-stage decimating receive front:
 * register offsets, reset values, field limits, datapath widths.
 * Assumes a byte-addressed plain register port with 32-bit data.
 */
`default_nettype none

package cicd_pkg;

    // Datapath widths
    localparam int CICD_IW = 16;          // Sample width in and out
    localparam int CICD_G2 = 8;           // Growth of 16^2
    localparam int CICD_G5 = 25;          // Growth of 32^5
    localparam int CICD_AW = 8;           // Register address width

    // Register byte offsets
    localparam logic [7:0] CICD_OFS_CTRL  = 8'h00;
    localparam logic [7:0] CICD_OFS_TUNE  = 8'h04;
    localparam logic [7:0] CICD_OFS_R2    = 8'h08;
    localparam logic [7:0] CICD_OFS_S2    = 8'h0c;
    localparam logic [7:0] CICD_OFS_R5    = 8'h10;
    localparam logic [7:0] CICD_OFS_S5    = 8'h14;
    localparam logic [7:0] CICD_OFS_STAT  = 8'h18;
    localparam logic [7:0] CICD_OFS_PHASE = 8'h1c;

    // Field positions
    localparam int CICD_CTRL_MS_BIT = 0;  // Master/slave select
    localparam int CICD_STAT_PEND_BIT = 1;

    // Reset values
    localparam logic        CICD_MS_RST   = 1'b1;
    localparam logic [31:0] CICD_TUNE_RST = 32'h0000_0000;
    localparam logic [4:0]  CICD_R2_RST   = 5'h01;
    localparam logic [2:0]  CICD_S2_RST   = 3'h0;
    localparam logic [5:0]  CICD_R5_RST   = 6'h01;
    localparam logic [4:0]  CICD_S5_RST   = 5'h00;

    // Field limits and shift biases
    localparam logic [4:0] CICD_R2_MAX  = 5'h10;
    localparam logic [2:0] CICD_S2_MAX  = 3'h6;
    localparam logic [5:0] CICD_R5_MAX  = 6'h20;
    localparam logic [4:0] CICD_S5_MAX  = 5'h14;
    localparam logic [5:0] CICD_S2_BIAS = 6'h02;
    localparam logic [5:0] CICD_S5_BIAS = 6'h05;

    // Complex sample pair from the mixer
    typedef struct packed {
        logic signed [CICD_IW-1:0] i;
        logic signed [CICD_IW-1:0] q;
    } cicd_iq_s;

    // One word of the shared I/Q stream
    typedef struct packed {
        logic                      is_q;
        logic signed [CICD_IW-1:0] data;
    } cicd_word_s;

endpackage

`default_nettype wire

// ---- test/cicd_adc_model.sv ----
/*
 * Converter model: one I/Q sample every fourth clock while run is high.
 * Assumes the bench sets the level; the lines carry its inverse between samples.
 */
`timescale 1ns/1ps
`default_nettype none
module cicd_adc_model
    import cicd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control from the bench
    input wire logic run,
    input wire cicd_iq_s level,
    // Mixer side
    output logic in_valid,
    output cicd_iq_s in_iq
);
    logic [1:0] gap_r; // Clocks since last sample
    wire logic fire = run && (gap_r == 2'h3); // Sample due
    // Rate stays at a quarter of the clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_r <= 2'h0;
            in_valid <= 1'b0;
            in_iq <= '0;
        end else begin
            gap_r <= gap_r + 2'h1;
            in_valid <= fire;
            in_iq <= fire ? level : ~level; // Inverse when idle
        end
    end
endmodule // cicd_adc_model
`default_nettype wire

// ---- test/cicd_chain_chk.sv ----
/*
 * Checker for the receive front, on its top ports only.
 * Assumes one clock domain; bound to every chain instance below.
 */
`timescale 1ns/1ps
`default_nettype none
module cicd_chain_chk
    import cicd_pkg::*;
(
    // Clock, reset, register port
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [CICD_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Streams and sync pin
    input wire logic in_valid,
    input wire logic out_valid,
    input wire cicd_word_s out_word,
    input wire logic [31:0] osc_phase,
    input wire logic osc_sync_pin_in,
    input wire logic osc_sync_pin_out,
    input wire logic osc_sync_pin_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic tune_hit = (reg_addr == CICD_OFS_TUNE); // Tuning word addressed
    wire logic ctrl_wr = reg_wr && (reg_addr == CICD_OFS_CTRL); // Role write
    logic [31:0] tune_r; // Shadow of the tuning word
    // Track tuning writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tune_r <= CICD_TUNE_RST;
        end else if (reg_wr && tune_hit) begin
            tune_r <= reg_wdata;
        end
    end
    AST_TUNE_SYNC:
    assert property ((reg_wr || reg_rd) && tune_hit && !osc_sync_pin_oe_n && !$past(ctrl_wr)
        |=> osc_sync_pin_out && osc_phase == 32'h0) else $error("tuning access gave no sync");
    AST_SLAVE_QUIET:
    assert property (osc_sync_pin_oe_n && $past(osc_sync_pin_oe_n) |-> !osc_sync_pin_out)
        else $error("sync pulse while slave");
    AST_SYNC_ZERO:
    assert property (osc_sync_pin_out |-> osc_phase == 32'h0) else $error("sync pulse off phase zero");
    AST_ROLE:
    assert property (ctrl_wr |=> ##1 osc_sync_pin_oe_n == !$past(reg_wdata[CICD_CTRL_MS_BIT], 2))
        else $error("pin direction does not follow role");
    AST_SLAVE_HOLD:
    assert property ((osc_sync_pin_oe_n && osc_sync_pin_in) [*4] |-> osc_phase == 32'h0)
        else $error("external sync did not hold phase");
    AST_TUNE_BACK:
    assert property (reg_rd && tune_hit |=> reg_rdata == tune_r) else $error("tuning word readback");
    AST_PAIR:
    assert property (out_valid && !out_word.is_q |=> out_valid && out_word.is_q) else $error("I word without Q");
    AST_OUT_LAT:
    assert property (out_valid && !out_word.is_q |-> $past(in_valid, 3)) else $error("output without input");
    // Main scenarios seen
    COV_PAIR: cover property (out_valid && out_word.is_q);
    COV_SYNC: cover property (osc_sync_pin_out);
    COV_HOLD: cover property (osc_sync_pin_oe_n && osc_sync_pin_in);
endmodule // cicd_chain_chk

bind cicd_chain cicd_chain_chk u_cicd_chain_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .in_valid, .out_valid, .out_word, .osc_phase, .osc_sync_pin_in, .osc_sync_pin_out,
    .osc_sync_pin_oe_n);
`default_nettype wire

// ---- test/tb_top.sv ----
/*
 * Bench for the receive front: registers, sync roles, decimation and scale.
 * Assumes the converter model on the mixer side and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import cicd_pkg::*;
;
    logic clk, rst_n, reg_wr, reg_rd, run, ext_sync, in_valid, out_valid, sync_out, sync_oe_n;
    logic [CICD_AW-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, osc_phase;
    logic [15:0] last_i, last_q; // Newest output pair
    cicd_iq_s in_iq, lvl;
    cicd_word_s out_word;
    longint e; // Expected word
    int fails, comparisons, nin, pairs, k, t, n, r, x;
    int c2[5] = '{1, 4, 16, 2, 1}; // Data cases
    int s2[5] = '{0, 1, 6, 0, 0}; // Second scales leave headroom, no overflow
    int c5[5] = '{1, 1, 1, 2, 32};
    int s5[5] = '{5, 0, 0, 1, 20}; // Fifth scales leave headroom, no overflow
    logic [7:0] ca[5] = '{CICD_OFS_R2, CICD_OFS_R2, CICD_OFS_S2, CICD_OFS_R5, CICD_OFS_S5};
    int cw[5] = '{0, 17, 7, 33, 21}; // Out-of-range writes
    int ce[5] = '{1, 16, 6, 32, 20};
    wire logic sync_pin = sync_oe_n ? ext_sync : sync_out; // Shared pin level
    // Design and converter
    cicd_chain u_cicd_chain (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .in_valid,
        .in_iq, .out_valid, .out_word, .osc_phase, .osc_sync_pin_in(sync_pin), .osc_sync_pin_out(sync_out),
        .osc_sync_pin_oe_n(sync_oe_n));
    cicd_adc_model u_cicd_adc_model (.clk, .rst_n, .run, .level(lvl), .in_valid, .in_iq);
    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Count inputs, keep the newest pair
    always @(posedge clk) begin
        nin += int'(in_valid === 1'b1);
        if (out_valid === 1'b1 && out_word.is_q) begin
            last_q = out_word.data;
        end else if (out_valid === 1'b1) begin
            last_i = out_word.data;
            pairs++;
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", exp, reg_rdata);
    endtask
    task automatic bound(input logic hit);
        if (hit) begin
            fails++;
            results();
        end
    endtask
    task automatic results;
        $display("comparisons %0d, fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {rst_n, reg_wr, reg_rd, run, ext_sync, reg_addr, reg_wdata} = '0;
        lvl = '0;
        {fails, comparisons, nin, pairs} = '0;
        void'($urandom(17));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(CICD_OFS_CTRL, 32'h1); // Master after reset
        rd(CICD_OFS_TUNE, CICD_TUNE_RST); // Tuning reset value
        chk("sync", 32'h1, sync_out); // Read forces sync
        for (k = 0; k < 5; k++) begin
            wr(ca[k], cw[k]);
            rd(ca[k], ce[k]); // Clamped fields
        end
        rd(8'h20, 32'h0); // Unmapped place
        x = $urandom;
        wr(CICD_OFS_TUNE, x);
        #1;
        chk("sync", 32'h1, sync_out); // Write forces sync
        chk("phase", 32'h0, osc_phase); // Phase cleared
        rd(CICD_OFS_TUNE, x); // Full word back
        wr(CICD_OFS_CTRL, 32'h0);
        run <= 1'b1;
        ext_sync <= 1'b1; // Common pulse to slaves
        repeat (12) @(posedge clk);
        #1;
        chk("phase", 32'h0, osc_phase); // Held by pin
        rd(CICD_OFS_PHASE, 32'h0); // Phase readback while held
        @(posedge clk);
        ext_sync <= 1'b0;
        wr(CICD_OFS_TUNE, 32'h4000_0000);
        #1;
        chk("sync", 32'h0, sync_out); // Slave stays quiet
        rd(CICD_OFS_STAT, 32'h2); // Owed sync flagged
        wr(CICD_OFS_CTRL, 32'h1);
        for (t = 0; t < 200 && sync_out !== 1'b1; t++) begin
            @(posedge clk);
            #1;
        end
        bound(t == 200);
        chk("phase", 32'h0, osc_phase); // Sync at wrap
        rd(CICD_OFS_STAT, 32'h1); // Owed flag cleared
        for (k = 0; k < 5; k++) begin
            x = 16 * $urandom_range(256, 1);
            wr(CICD_OFS_R2, c2[k]);
            wr(CICD_OFS_S2, s2[k]);
            wr(CICD_OFS_R5, c5[k]);
            wr(CICD_OFS_S5, s5[k]);
            lvl <= '{i: 16'(x), q: 16'(-x)};
            r = c2[k] * c5[k];
            n = (8 * c5[k] + 4) * c2[k] + 8; // Room for combs and windows to settle
            @(negedge clk);
            {nin, pairs} = '0;
            for (t = 0; t < 8 * n && nin < n; t++) begin
                @(posedge clk);
            end
            bound(t == 8 * n);
            e = (longint'(x) * c2[k] * c2[k]) >>> (s2[k] + 2);
            if (c5[k] > 1) begin
                e = (e * c5[k] ** 5) >>> (s5[k] + 5);
            end
            chk("i word", {16'h0000, 16'(e)}, last_i); // Gain and shift
            chk("q word", {16'h0000, 16'(-e)}, last_q); // Quadrature path
            chk("pairs", 32'h1, pairs * r <= nin + 2 * r && pairs * r + 2 * r >= nin); // Rate
        end
        results();
    end
endmodule // tb_top
`default_nettype wire
